// file: analog_converter_control.sv
/*
  Control logic for a 10-bit successive-approximation converter: register
  file, prescaler, conversion sequencer, selection latching and result
  presentation. Assumes the analog core supplies a 10-bit code that is
  stable on the cycle its conversion is closed, in the core clock domain,
  and that the trigger input is a same-clock level.
*/
// Notes on behaviour
// - Reference field decodes external, supply, reserved, internal.
// - Selection changes wait for conversion end.
// - Left adjust changes result presentation immediately.
// - Selection bit 4 always reads zero.
// - Channel codes map inputs, sensor, bandgap, ground.
// - Channel 1000 enables the temperature sensor.
// - Result code scales input against reference.
// - Result registers filled in the same cycle as the done flag.
// - Enable powers converter; clearing aborts conversion.
// - Start bit begins single or first free-run.
// - First conversion after enable takes 25 cycles.
// - Start reads one while busy; zero ignored.
// - Done flag set on finish, cleared by one.
// - Prescaler field divides system clock.
// - Low byte read freezes result until high.
// - Auto trigger starts on trigger rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_cfg.svh"
module analog_converter_control
  import adc_ctrl_pkg::*;
#(
  parameter int RESULT_W = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire reg_req_t regReq,
  output logic [7:0] regRdata,
  // Analog core
  input wire logic [RESULT_W-1:0] analogCode,
  output analog_ctl_t analogCtl,
  // Trigger and interrupt vector acknowledge
  input wire logic triggerSource,
  input wire logic vectorAck,
  output logic doneIrq
);

  logic enable, start, autoTrig, doneFlag, irqEn, leftAdjust, freeRun;
  logic [2:0] prescale;
  logic [1:0] refPending, refActive;
  logic [3:0] chPending, chActive;
  logic firstPending, frozen, trigPrev;
  logic [6:0] divCount;
  logic adcTick;
  logic [5:0] cycleCount, convLength;
  logic [RESULT_W-1:0] result, shownResult;
  conv_state_t state;

  logic wrA, wrMux, wrB, startReq, finish, trigEdge, beginConv;
  logic [7:0] wd;
  logic [6:0] divMask;
  logic [15:0] presented;

  assign wd = regReq.wdata;
  assign wrA = regReq.wr && regReq.addr == `OFF_CONTROL_STATUS_A;
  assign wrB = regReq.wr && regReq.addr == `OFF_CONTROL_STATUS_B;
  assign wrMux = regReq.wr && regReq.addr == `OFF_REFERENCE_CHANNEL_SELECT;
  assign trigEdge = autoTrig && triggerSource && !trigPrev;
  // A written start needs enable set in the same write.
  assign startReq = (wrA && wd[`BIT_START] && wd[`BIT_ENABLE]) || trigEdge;
  assign finish = state == CONVERT && adcTick && cycleCount == convLength - 6'h01;
  assign beginConv = state == IDLE && enable && (startReq || start);

  // Codes 000 and 001 both divide by two.
  always_comb begin
    case (prescale)
      3'h0, 3'h1: divMask = 7'h01;
      3'h2: divMask = 7'h03;
      3'h3: divMask = 7'h07;
      3'h4: divMask = 7'h0f;
      3'h5: divMask = 7'h1f;
      3'h6: divMask = 7'h3f;
      default: divMask = 7'h7f;
    endcase
  end

  // Prescaler restarts on a trigger so its delay is fixed.
  always_ff @(posedge core_clk) begin
    if (rst || !enable || trigEdge) begin
      divCount <= 7'h00;
      adcTick <= 1'b0;
    end else begin
      divCount <= (divCount & divMask) == divMask ? 7'h00 : divCount + 7'h01;
      adcTick <= (divCount & divMask) == divMask;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      trigPrev <= 1'b0;
    end else begin
      trigPrev <= triggerSource;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      enable <= 1'b0;
      autoTrig <= 1'b0;
      irqEn <= 1'b0;
      prescale <= 3'h0;
      freeRun <= 1'b0;
    end else begin
      if (wrA) begin
        enable <= wd[`BIT_ENABLE];
        autoTrig <= wd[`BIT_AUTO_TRIGGER];
        irqEn <= wd[`BIT_DONE_IRQ_EN];
        prescale <= wd[2:0];
      end
      if (wrB) begin
        freeRun <= wd[2:0] == 3'h0;
      end
    end
  end

  // First conversion after an enable runs the initialisation cycles.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      firstPending <= 1'b0;
    end else if (wrA && wd[`BIT_ENABLE] && !enable) begin
      firstPending <= 1'b1;
    end else if (wrA && !wd[`BIT_ENABLE]) begin
      firstPending <= 1'b0;
    end else if (finish) begin
      firstPending <= 1'b0;
    end
  end

  // Start stays high from request to completion.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      start <= 1'b0;
    end else if ((wrA && !wd[`BIT_ENABLE]) || (!enable && !wrA)) begin
      start <= 1'b0;
    end else if (startReq) begin
      start <= 1'b1;
    end else if (finish && !(autoTrig && freeRun)) begin
      start <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= IDLE;
      cycleCount <= 6'h00;
      convLength <= `NORMAL_CONV_CYCLES;
    end else if (!enable || (wrA && !wd[`BIT_ENABLE])) begin
      state <= IDLE;
      cycleCount <= 6'h00;
    end else begin
      case (state)
        IDLE: begin
          if (beginConv) begin
            state <= CONVERT;
            cycleCount <= 6'h00;
            convLength <= firstPending ? `FIRST_CONV_CYCLES : `NORMAL_CONV_CYCLES;
          end
        end
        CONVERT: begin
          if (finish) begin
            // Free running re-arms at once on the latched selection.
            state <= autoTrig && freeRun ? CONVERT : IDLE;
            cycleCount <= 6'h00;
            convLength <= `NORMAL_CONV_CYCLES;
          end else if (adcTick) begin
            cycleCount <= cycleCount + 6'h01;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Pending selection is software's; active is locked while converting.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      refPending <= 2'h0;
      leftAdjust <= 1'b0;
      chPending <= 4'h0;
    end else if (wrMux) begin
      refPending <= wd[7:6];
      leftAdjust <= wd[`BIT_LEFT_ADJUST];
      chPending <= wd[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      refActive <= 2'h0;
      chActive <= 4'h0;
    end else if (state == IDLE || finish) begin
      refActive <= refPending;
      chActive <= chPending;
    end
  end

  // Result updates at finish, in the same cycle the flag is set.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      result <= '0;
      shownResult <= '0;
      frozen <= 1'b0;
    end else begin
      if (finish) begin
        result <= analogCode;
      end
      if (!frozen) begin
        shownResult <= finish ? analogCode : result;
      end
      if (regReq.rd && regReq.addr == `OFF_RESULT_LOW) begin
        frozen <= 1'b1;
      end else if (regReq.rd && regReq.addr == `OFF_RESULT_HIGH) begin
        frozen <= 1'b0;
      end
    end
  end

  // A finish in the clearing cycle keeps the flag set.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      doneFlag <= 1'b0;
    end else if (finish) begin
      doneFlag <= 1'b1;
    end else if ((wrA && wd[`BIT_DONE_FLAG]) || vectorAck) begin
      doneFlag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      doneIrq <= 1'b0;
    end else begin
      doneIrq <= doneFlag && irqEn;
    end
  end

  // Presentation follows left adjust at once.
  assign presented = leftAdjust ? {shownResult, 6'h00} : {6'h00, shownResult};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regReq.rd) begin
      case (regReq.addr)
        `OFF_CONTROL_STATUS_A:
          regRdata <= {enable, start, autoTrig, doneFlag, irqEn, prescale};
        `OFF_CONTROL_STATUS_B: regRdata <= {7'h00, freeRun};
        `OFF_REFERENCE_CHANNEL_SELECT:
          regRdata <= {refPending, leftAdjust, 1'b0, chPending};
        `OFF_RESULT_LOW: regRdata <= presented[7:0];
        `OFF_RESULT_HIGH: regRdata <= presented[15:8];
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // Reserved reference code drives nothing; reserved channels connect nothing.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      analogCtl <= '0;
    end else begin
      analogCtl.reference <= refActive;
      analogCtl.channel <= chActive;
      analogCtl.tempSensorOn <= chActive == `CH_TEMP_SENSOR;
      analogCtl.internalRefOn <= refActive == `REF_INTERNAL || chActive == `CH_BANDGAP;
      analogCtl.convPowered <= enable;
      analogCtl.sampleHold <= beginConv;
      analogCtl.convActive <= state == CONVERT && !finish;
    end
  end

endmodule // analog_converter_control
`default_nettype wire

// file: adc_ctrl_cfg.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  analog converter control block. Assumes inclusion from the package and the control block.
*/
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH
`define OFF_CONTROL_STATUS_A 8'h7a
`define OFF_CONTROL_STATUS_B 8'h7b
`define OFF_REFERENCE_CHANNEL_SELECT 8'h7c
`define OFF_RESULT_LOW 8'h78
`define OFF_RESULT_HIGH 8'h79
`define RST_CONTROL_STATUS_A 8'h00
`define RST_REFERENCE_CHANNEL_SELECT 8'h00
`define BIT_ENABLE 7
`define BIT_START 6
`define BIT_AUTO_TRIGGER 5
`define BIT_DONE_FLAG 4
`define BIT_DONE_IRQ_EN 3
`define BIT_LEFT_ADJUST 5
`define FIRST_CONV_CYCLES 6'h19
`define NORMAL_CONV_CYCLES 6'h0d
`define CH_TEMP_SENSOR 4'h8
`define CH_BANDGAP 4'he
`define CH_GROUND 4'hf
`define REF_EXTERNAL 2'h0
`define REF_SUPPLY 2'h1
`define REF_INTERNAL 2'h3
`endif

// file: adc_ctrl_pkg.sv
/*
  Types shared by the analog converter control block.
  Assumes the configuration header sits in the same folder.
*/
`include "adc_ctrl_cfg.svh"
package adc_ctrl_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic [1:0] reference;
    logic [3:0] channel;
    logic tempSensorOn;
    logic internalRefOn;
    logic convPowered;
    logic sampleHold;
    logic convActive;
  } analog_ctl_t;
  typedef enum logic [1:0] {IDLE, CONVERT} conv_state_t;
endpackage

// file: analog_core_model.sv
/* Analog core model: hands back a code built from the active selection.
   Assumes the control block samples the code on its finish cycle. */
`timescale 1ns/1ps
`default_nettype none
module analog_core_model
  import adc_ctrl_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Control and code
  input wire analog_ctl_t ctl,
  output logic [9:0] code
);
  initial code = 10'h155;
  // Outside a conversion the code toggles, so a stale value is never taken.
  always @(posedge core_clk) begin
    code <= ctl.convActive ? {ctl.reference, ctl.channel, 4'ha} : ~code;
  end
endmodule // analog_core_model
`default_nettype wire

// file: analog_converter_control_asserts.sv
/* Port assertions for the converter control block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module analog_converter_control_asserts
  import adc_ctrl_pkg::*;
#(
  parameter int RESULT_W = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Watched ports
  input wire reg_req_t regReq,
  input wire logic [7:0] regRdata,
  input wire logic [RESULT_W-1:0] analogCode,
  input wire analog_ctl_t analogCtl,
  input wire logic triggerSource,
  input wire logic vectorAck,
  input wire logic doneIrq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic act;
  logic csWr;
  assign act = analogCtl.convActive;
  assign csWr = regReq.wr && regReq.addr == 8'h7a;
  a_power_on: assert property (csWr && regReq.wdata[7] |-> ##[1:2] analogCtl.convPowered)
    else $error("converter not powered");
  a_off_abort: assert property (csWr && !regReq.wdata[7] |-> ##[1:2] !act)
    else $error("conversion not aborted");
  a_sensor_on: assert property (analogCtl.channel == 4'h8 && $stable(analogCtl.channel)
    && !act |-> analogCtl.tempSensorOn)
    else $error("sensor not enabled");
  a_ref_internal: assert property (analogCtl.reference == 2'h3
    && $stable(analogCtl.reference) && !act |-> analogCtl.internalRefOn)
    else $error("internal reference off");
  a_sel_locked: assert property (act && $past(act) |-> $stable(analogCtl.channel)
    && $stable(analogCtl.reference))
    else $error("selection moved in conversion");
  a_idle_unpowered: assert property (!analogCtl.convPowered
    && !$past(analogCtl.convPowered) |=> !act)
    else $error("conversion while off");
  a_sample_start: assert property (analogCtl.sampleHold |-> ##[0:1] act)
    else $error("sample outside conversion");
  a_conv_min: assert property ($rose(act) |-> act[*8])
    else $error("conversion too short");
  a_ack_clear: assert property (vectorAck |-> ##[1:2] !doneIrq)
    else $error("irq not cleared");
  cover property ($rose(act));
  cover property (analogCtl.tempSensorOn);
  cover property ($rose(doneIrq));
endmodule // analog_converter_control_asserts
bind analog_converter_control analog_converter_control_asserts #(.RESULT_W(RESULT_W)) uChk (
  .core_clk(core_clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
  .analogCode(analogCode), .analogCtl(analogCtl), .triggerSource(triggerSource),
  .vectorAck(vectorAck), .doneIrq(doneIrq));
`default_nettype wire

// file: analog_converter_control_test.sv
/* Bench for the converter control block: register rows, then conversions.
   Assumes the core model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module analog_converter_control_test;
  import adc_ctrl_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  row_t rows [5] = '{'{8'h7c, 8'hff, 8'hef}, '{8'h7c, 8'h10, 8'h00},
    '{8'h7a, 8'h0f, 8'h0f}, '{8'h40, 8'hff, 8'h00}, '{8'h7a, 8'h00, 8'h00}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic trig = 1'b0;
  logic ack = 1'b0;
  logic irq;
  logic [7:0] rdata;
  logic [9:0] code;
  reg_req_t req = '0;
  analog_ctl_t ctl;
  int errTotal = 0;
  int checked = 0;
  int n1, n2;
  analog_converter_control DUT (.core_clk(clk), .rst(rst), .regReq(req), .regRdata(rdata),
    .analogCode(code), .analogCtl(ctl), .triggerSource(trig), .vectorAck(ack), .doneIrq(irq));
  analog_core_model core (.core_clk(clk), .ctl(ctl), .code(code));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic end_of_test(input bit hung);
    if (hung) errTotal++;
    $display("checked %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Counts the cycles a conversion stays active; a hang ends the run.
  task automatic conv(output int n);
    int i;
    n = 0;
    for (i = 0; i < 300 && ctl.convActive !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    while (ctl.convActive === 1'b1 && n < 9000) begin
      @(posedge clk);
      #1 n++;
    end
    if (i == 300 || n == 9000) end_of_test(1'b1);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      rchk(rows[k].a, rows[k].e);
    end
    $display("test rows done");
    wr(8'h7c, 8'hc8);
    repeat (3) @(posedge clk);
    #1 chk({ctl.tempSensorOn, ctl.internalRefOn, ctl.channel}, 16'h38);
    wr(8'h7a, 8'hc0);
    conv(n1);
    rchk(8'h7a, 8'h90);
    rchk(8'h78, 8'h8a);
    rchk(8'h79, 8'h03);
    wr(8'h7c, 8'he8);
    rchk(8'h78, 8'h80);
    rchk(8'h79, 8'he2);
    wr(8'h7a, 8'hd0);
    wr(8'h7c, 8'h41);
    rchk(8'h7a, 8'hc0);
    chk(ctl.channel, 16'h8);
    conv(n2);
    // The selection reaches the pins one cycle after the activity drops.
    repeat (2) @(posedge clk);
    #1 chk(ctl.channel, 16'h1);
    wr(8'h7a, 8'hd0);
    conv(n2);
    chk(n1 - n2, 16'd24);
    rchk(8'h78, 8'h1a);
    wr(8'h7c, 8'hc8);
    wr(8'h7a, 8'hd0);
    conv(n2);
    rchk(8'h79, 8'h01);
    $display("test conversions done");
    wr(8'h7a, 8'hd0);
    repeat (12) @(posedge clk);
    wr(8'h7a, 8'h10);
    rchk(8'h7a, 8'h00);
    chk(ctl.convActive, 16'h0);
    wr(8'h7a, 8'h40);
    rchk(8'h7a, 8'h00);
    wr(8'h7a, 8'h80);
    rchk(8'h7a, 8'h80);
    // Puts the start on the same prescaler phase as the first conversion.
    @(posedge clk);
    wr(8'h7a, 8'hc8);
    conv(n2);
    chk(n2, n1);
    rchk(8'h7a, 8'h98);
    chk(irq, 16'h1);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(irq, 16'h0);
    $display("test abort and irq done");
    wr(8'h7b, 8'h01);
    wr(8'h7a, 8'ha0);
    trig <= 1'b1;
    conv(n2);
    chk(n2 > 0, 16'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h7a, 8'h00);
    rchk(8'h7c, 8'h00);
    $display("test trigger and reset done");
    end_of_test(1'b0);
  end
endmodule // analog_converter_control_test
`default_nettype wire
